// >>> rtl/dacc_pkg.sv
// Constants and state types shared by the DAC control core
package dacc_pkg;
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int CODE_W = 16;
    localparam int FRAME_W = 32;

    // Register addresses, bit 23 of the command selects a read
    localparam logic [6:0] ADDR_NOP = 7'h00;
    localparam logic [6:0] ADDR_SOFT_RESET = 7'h01;
    localparam logic [6:0] ADDR_RESET_CFG = 7'h02;
    localparam logic [6:0] ADDR_CHAN_SEL = 7'h03;
    localparam logic [6:0] ADDR_CHAN_CFG = 7'h04;
    localparam logic [6:0] ADDR_CHAN_CODE = 7'h05;
    localparam logic [6:0] ADDR_CONV_SEL = 7'h06;
    localparam logic [6:0] ADDR_CONV_CFG = 7'h07;
    localparam logic [6:0] ADDR_TRIM_EN = 7'h08;
    localparam logic [6:0] ADDR_GAIN_TRIM = 7'h09;
    localparam logic [6:0] ADDR_OFFSET_TRIM = 7'h0A;
    localparam logic [6:0] ADDR_FAULT_STATUS = 7'h0B;
    localparam logic [6:0] ADDR_FAULT_MASK = 7'h0C;
    localparam logic [6:0] ADDR_FAULT_ACTION = 7'h0D;
    localparam logic [6:0] ADDR_FAULT_CODE = 7'h0E;
    localparam logic [6:0] ADDR_WATCHDOG = 7'h10;
    localparam logic [6:0] ADDR_PART_ID = 7'h11;

    // Field positions
    localparam int CMD_READ_BIT = 23;
    localparam int SOFT_RESET_BIT = 0;
    localparam int RCFG_POC_BIT = 1;
    localparam int RCFG_SW_CLEAR_BIT = 2;
    localparam int RCFG_CLEAR_ALLOW_LSB = 9;
    localparam int SEL_FRAME_CHECK_BIT = 3;
    localparam int SEL_CHAN_LSB = 5;
    localparam int SEL_CLEAR_LEVEL_LSB = 9;
    localparam int CONV_SEL_LSB = 0;
    localparam int TRIM_EN_BIT = 0;
    localparam int STAT_CRC_ERR_BIT = 5;
    localparam int MASK_CRC_ERR_BIT = 5;

    // Reset values and codes
    localparam logic [15:0] STATUS_RESET = 16'h1000;
    localparam logic [15:0] GAIN_RESET = 16'h8000;
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_MID = 16'h8000;
    localparam logic [15:0] CODE_MAX = 16'hFFFF;
    localparam logic [16:0] GAIN_BIAS = 17'h0_8000;

    // Frame check
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [5:0] FRAME_PLAIN_BITS = 6'h18;
    localparam logic [5:0] FRAME_CHECKED_BITS = 6'h20;
    localparam logic [5:0] COUNT_MAX = 6'h3F;

    typedef struct packed {
        logic [1:0] selSync;
        logic [1:0] clrSync;
        logic [1:0] ldSync;
        logic selPrev;
        logic ldPrev;
        logic softReset;
        logic [15:0] resetCfg;
        logic [15:0] chanSel;
        logic [15:0] convSel;
        logic [15:0] status;
        logic [15:0] faultMask;
        logic [15:0] faultAction;
        logic [NUM_CH-1:0][15:0] chanCfg;
        logic [NUM_CH-1:0][15:0] code;
        logic [NUM_CH-1:0][15:0] convCfg;
        logic [NUM_CH-1:0][15:0] gain;
        logic [NUM_CH-1:0][15:0] offs;
        logic [NUM_CH-1:0][15:0] faultCode;
        logic [NUM_CH-1:0][15:0] latch;
        logic [NUM_CH-1:0][15:0] dacOut;
        logic [NUM_CH-1:0] trim;
        logic [NUM_CH-1:0] cleared;
        logic faultN;
        logic [FRAME_W-1:0] readFrame;
    } dacc_core_t;

    typedef struct packed {
        logic [FRAME_W-1:0] shiftIn;
        logic [FRAME_W-1:0] shiftOut;
        logic [5:0] count;
    } dacc_link_t;
endpackage

// >>> rtl/dacc_control_core.sv
// DAC control core: serial command link, register map, clear handling and trim
`timescale 1ns/1ns
`default_nettype none

module dacc_control_core #(
    parameter logic [2:0] PART_ID = 3'h5 // Arbitrary identity value
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Serial link
    input wire logic serialClk,
    input wire logic frameSelN,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutEn,
    // Control pins
    input wire logic outputClearInput,
    input wire logic outputLoadStrobeN,
    // Status and outputs
    output logic faultN,
    output logic [dacc_pkg::NUM_CH-1:0][dacc_pkg::CODE_W-1:0] dacCode
);
    import dacc_pkg::*;

    dacc_core_t core;
    dacc_core_t next_core;
    dacc_link_t link;
    dacc_link_t next_link;
    logic frameFresh;
    logic freshPreset;

    // Remainder of d times x^8, bit 31 first
    function automatic logic [7:0] crc8(input logic [31:0] d);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 31; i >= 0; i--) begin
            r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? CRC_POLY : 8'h00);
        end
        return r;
    endfunction

    function automatic logic [15:0] trimCode(input logic [15:0] c, input logic [15:0] g,
                                              input logic [15:0] o, input logic en);
        logic [32:0] prod;
        logic signed [18:0] sum;
        prod = 33'(c) * 33'(17'(g) + GAIN_BIAS);
        sum = $signed({2'b00, prod[32:16]}) + $signed({{3{o[15]}}, o});
        if (!en) begin
            return c;
        end else if (sum < 0) begin
            return CODE_ZERO;
        end else if (sum > $signed({3'b000, CODE_MAX})) begin
            return CODE_MAX;
        end
        return sum[15:0];
    endfunction

    // Link side, on the host's serial clock
    assign freshPreset = frameSelN | rst;

    always_ff @(posedge serialClk or posedge freshPreset) begin
        if (freshPreset) begin
            frameFresh <= 1'b1;
        end else begin
            frameFresh <= 1'b0;
        end
    end

    always_comb begin
        next_link = link;
        if (!frameSelN) begin
            next_link.shiftIn = {link.shiftIn[FRAME_W-2:0], serialIn};
            if (frameFresh) begin
                // Read word is static here: it changes only between frames
                next_link.count = 6'h01;
                next_link.shiftOut = {core.readFrame[FRAME_W-2:0], 1'b0};
            end else begin
                next_link.count = (link.count == COUNT_MAX) ? COUNT_MAX : link.count + 6'h01;
                next_link.shiftOut = {link.shiftOut[FRAME_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge serialClk or posedge rst) begin
        if (rst) begin
            link <= '0;
        end else begin
            link <= next_link;
        end
    end

    assign serialOut = frameFresh ? core.readFrame[FRAME_W-1] : link.shiftOut[FRAME_W-1];
    assign serialOutEn = ~frameSelN & ~rst;

    // Frame decode, read only while select is settled high
    logic frameEnd;
    logic crcOn;
    logic enough;
    logic crcBad;
    logic [23:0] cmd;
    logic [6:0] addr;
    logic [15:0] data;
    logic writeGo;
    logic readGo;
    logic clearPin;
    logic ldFall;
    logic [NUM_CH-1:0] dacHit;
    logic [NUM_CH-1:0] convHit;
    logic [NUM_CH-1:0] clrActive;
    logic [CH_W-1:0] rdCh;
    logic [CH_W-1:0] convCh;
    logic [15:0] rdWord;
    logic [23:0] rdBody;

    // Link words are read here only once select has settled high;
    // the host keeps its clock still then, so they are quasi-static.
    assign frameEnd = core.selSync[1] & ~core.selPrev;
    assign crcOn = core.chanSel[SEL_FRAME_CHECK_BIT];
    assign enough = crcOn ? (link.count >= FRAME_CHECKED_BITS) : (link.count >= FRAME_PLAIN_BITS);
    assign crcBad = crcOn && (crc8(link.shiftIn) != 8'h00);
    assign cmd = crcOn ? link.shiftIn[31:8] : link.shiftIn[23:0];
    assign addr = cmd[22:16];
    assign data = cmd[15:0];
    assign writeGo = frameEnd & enough & ~crcBad & ~cmd[CMD_READ_BIT];
    assign readGo = frameEnd & enough & ~crcBad & cmd[CMD_READ_BIT];
    assign clearPin = core.clrSync[1];
    assign ldFall = core.ldPrev & ~core.ldSync[1];
    assign dacHit = core.chanSel[SEL_CHAN_LSB +: NUM_CH];
    assign convHit = core.convSel[CONV_SEL_LSB +: NUM_CH];

    for (genvar i = 0; i < NUM_CH; i++) begin : g_clear
        assign clrActive[i] = (clearPin | core.resetCfg[RCFG_SW_CLEAR_BIT])
                              & core.resetCfg[RCFG_CLEAR_ALLOW_LSB + i];
    end

    // Readback source: lowest selected channel
    always_comb begin
        rdCh = '0;
        convCh = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (dacHit[i]) begin
                rdCh = CH_W'(i);
            end
            if (convHit[i]) begin
                convCh = CH_W'(i);
            end
        end
        case (addr)
            ADDR_SOFT_RESET: rdWord = 16'(core.softReset);
            ADDR_RESET_CFG: rdWord = core.resetCfg;
            ADDR_CHAN_SEL: rdWord = core.chanSel;
            ADDR_CHAN_CFG: rdWord = core.chanCfg[rdCh];
            ADDR_CHAN_CODE: rdWord = core.code[rdCh];
            ADDR_CONV_SEL: rdWord = core.convSel;
            ADDR_CONV_CFG: rdWord = core.convCfg[convCh];
            ADDR_TRIM_EN: rdWord = 16'(core.trim[rdCh]);
            ADDR_GAIN_TRIM: rdWord = core.gain[rdCh];
            ADDR_OFFSET_TRIM: rdWord = core.offs[rdCh];
            ADDR_FAULT_STATUS: rdWord = core.status;
            ADDR_FAULT_MASK: rdWord = core.faultMask;
            ADDR_FAULT_ACTION: rdWord = core.faultAction;
            ADDR_FAULT_CODE: rdWord = core.faultCode[rdCh];
            ADDR_PART_ID: rdWord = 16'(PART_ID);
            default: rdWord = 16'h0000;
        endcase
        rdBody = {cmd[23:16], rdWord};
    end

    // Core side, on ref_clk
    always_comb begin
        next_core = core;
        next_core.selSync = {core.selSync[0], frameSelN};
        next_core.clrSync = {core.clrSync[0], outputClearInput};
        next_core.ldSync = {core.ldSync[0], outputLoadStrobeN};
        next_core.selPrev = core.selSync[1];
        next_core.ldPrev = core.ldSync[1];
        next_core.softReset = 1'b0;

        if (frameEnd && enough) begin
            // Every accepted frame replaces the pending readback word
            next_core.readFrame = '0;
        end
        if (readGo) begin
            next_core.readFrame = crcOn ? {rdBody, crc8({8'h00, rdBody})} : {rdBody, 8'h00};
        end
        if (frameEnd && enough && crcBad) begin
            next_core.status[STAT_CRC_ERR_BIT] = 1'b1;
        end

        if (writeGo) begin
            case (addr)
                ADDR_SOFT_RESET: next_core.softReset = data[SOFT_RESET_BIT];
                ADDR_RESET_CFG: next_core.resetCfg = data;
                ADDR_CHAN_SEL: next_core.chanSel = data;
                ADDR_CONV_SEL: next_core.convSel = data;
                ADDR_FAULT_MASK: next_core.faultMask = data;
                ADDR_FAULT_ACTION: next_core.faultAction = data;
                // No-op, watchdog restart, status and reserved slots store nothing
                default: next_core.softReset = 1'b0;
            endcase
        end

        for (int i = 0; i < NUM_CH; i++) begin
            if (writeGo && dacHit[i]) begin
                case (addr)
                    ADDR_CHAN_CFG: next_core.chanCfg[i] = data;
                    ADDR_CHAN_CODE: begin
                        next_core.code[i] = data;
                        // Load strobe held low: latch follows the write at once
                        if (!core.ldSync[1] && !clearPin) begin
                            next_core.latch[i] = trimCode(data, core.gain[i], core.offs[i], core.trim[i]);
                            next_core.cleared[i] = 1'b0;
                        end
                    end
                    ADDR_TRIM_EN: next_core.trim[i] = data[TRIM_EN_BIT];
                    ADDR_GAIN_TRIM: next_core.gain[i] = data;
                    ADDR_OFFSET_TRIM: next_core.offs[i] = data;
                    ADDR_FAULT_CODE: next_core.faultCode[i] = data;
                    default: next_core.chanCfg[i] = core.chanCfg[i];
                endcase
            end
            if (writeGo && convHit[i] && addr == ADDR_CONV_CFG) begin
                next_core.convCfg[i] = data;
            end
            if (ldFall && !clearPin) begin
                next_core.latch[i] = trimCode(core.code[i], core.gain[i], core.offs[i], core.trim[i]);
                next_core.cleared[i] = 1'b0;
            end
            if (clrActive[i]) begin
                // Set wins over a load in the same cycle
                next_core.cleared[i] = 1'b1;
            end
            // Clear code goes straight to the output; no stepping exists here
            if (clrActive[i] || core.cleared[i]) begin
                next_core.dacOut[i] = core.chanSel[SEL_CLEAR_LEVEL_LSB + i] ? CODE_MID : CODE_ZERO;
            end else begin
                next_core.dacOut[i] = core.latch[i];
            end
        end

        if (!next_core.chanSel[SEL_FRAME_CHECK_BIT]) begin
            next_core.status[STAT_CRC_ERR_BIT] = 1'b0;
        end

        if (core.softReset) begin
            next_core = '0;
            next_core.selSync = core.selSync;
            next_core.clrSync = core.clrSync;
            next_core.ldSync = core.ldSync;
            next_core.selPrev = core.selPrev;
            next_core.ldPrev = core.ldPrev;
            next_core.resetCfg[RCFG_POC_BIT] = core.resetCfg[RCFG_POC_BIT];
            next_core.gain = {NUM_CH{GAIN_RESET}};
            next_core.status = STATUS_RESET;
        end
        next_core.faultN = ~(next_core.status[STAT_CRC_ERR_BIT] & ~next_core.faultMask[MASK_CRC_ERR_BIT]);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            core <= '0;
            core.gain <= {NUM_CH{GAIN_RESET}};
            core.status <= STATUS_RESET;
            core.faultN <= 1'b1;
            // Syncs start at the pins' idle levels so no false edge follows reset
            core.selSync <= 2'b11;
            core.selPrev <= 1'b1;
            core.ldSync <= 2'b11;
            core.ldPrev <= 1'b1;
        end else begin
            core <= next_core;
        end
    end

    assign faultN = core.faultN;
    assign dacCode = core.dacOut;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_crc_flag_set: assert property (frameEnd && enough && crcBad |=> core.status[STAT_CRC_ERR_BIT])
        else $error("CRC error flag not set after bad frame");
    a_crc_fault_pin: assert property (frameEnd && enough && crcBad && !core.faultMask[MASK_CRC_ERR_BIT]
                                      |=> !faultN)
        else $error("Fault pin not low after bad frame");
    a_crc_no_write: assert property (frameEnd && crcBad |=> core.code == $past(core.code)
                                     && core.chanSel == $past(core.chanSel))
        else $error("Bad frame changed a register");
    a_flag_needs_check: assert property (core.status[STAT_CRC_ERR_BIT] |-> crcOn)
        else $error("CRC error flag set while checking disabled");
    a_short_frame: assert property (frameEnd && !enough |=> core.code == $past(core.code)
                                    && core.resetCfg == $past(core.resetCfg))
        else $error("Short frame was acted on");
    a_clear_level: assert property (clrActive[0] && !core.softReset |=> dacCode[0]
                                    == ($past(core.chanSel[SEL_CLEAR_LEVEL_LSB]) ? CODE_MID : CODE_ZERO))
        else $error("Cleared channel shows wrong code");
    a_clear_blocks_load: assert property (clearPin && !core.softReset |=> core.latch == $past(core.latch))
        else $error("Latch loaded while clear high");
    a_clear_keeps_regs: assert property (clrActive[0] && !writeGo && !core.softReset |=> core.code == $past(core.code)
                                         && core.gain == $past(core.gain) && core.offs == $past(core.offs))
        else $error("Clear altered trim or code registers");
    a_cleared_hold: assert property (core.cleared[0] && !core.softReset |=> dacCode[0]
                                     == ($past(core.chanSel[SEL_CLEAR_LEVEL_LSB]) ? CODE_MID : CODE_ZERO))
        else $error("Cleared channel left clear state early");
    a_soft_reset: assert property (core.softReset |=> core.gain[0] == GAIN_RESET
                                   && core.status == STATUS_RESET && core.code[0] == CODE_ZERO)
        else $error("Soft reset left a register set");
    a_trim_bypass: assert property (writeGo && addr == ADDR_CHAN_CODE && dacHit[0] && !core.trim[0]
                                    && !core.ldSync[1] && !clearPin |=> core.latch[0] == $past(data))
        else $error("Untrimmed code not loaded as written");

    // Link, readback and flag checks
    a_flag_off_clear: assert property (!crcOn |=> !core.status[STAT_CRC_ERR_BIT])
        else $error("CRC error flag survived with checking off");
    a_fault_follows: assert property (core.status[STAT_CRC_ERR_BIT]
                                      && !core.faultMask[MASK_CRC_ERR_BIT] |-> !faultN)
        else $error("Fault pin high while CRC error flag set");
    a_read_header: assert property (readGo && !core.softReset
                                    |=> core.readFrame[FRAME_W-1:FRAME_W-8] == $past(cmd[23:16]))
        else $error("Readback word lost its command byte");
    a_read_check: assert property (readGo && crcOn && !core.softReset
                                   |=> crc8(core.readFrame) == 8'h00)
        else $error("Readback frame check code wrong");

    // Output and clear checks
    a_clear_allow: assert property (!core.resetCfg[RCFG_CLEAR_ALLOW_LSB] && !core.cleared[0]
                                    |=> !core.cleared[0])
        else $error("Channel cleared without its clear-allow bit");
    a_clear_mid_one: assert property (clrActive[1] && !core.softReset |=> dacCode[1]
                                      == ($past(core.chanSel[SEL_CLEAR_LEVEL_LSB + 1]) ? CODE_MID : CODE_ZERO))
        else $error("Channel one shows wrong clear code");
    a_load_uncleared: assert property (ldFall && !clearPin && !clrActive[0] && !core.softReset
                                       |=> !core.cleared[0])
        else $error("Load strobe left channel cleared");
    a_latch_steady: assert property (!ldFall && !writeGo && !core.softReset
                                     |=> core.latch == $past(core.latch))
        else $error("Latch changed with no load or write");
    a_soft_outputs: assert property (core.softReset |=> dacCode == '0 && faultN)
        else $error("Soft reset left an output set");

    c_bad_frame: cover property (frameEnd && enough && crcBad);
    c_read_frame: cover property (readGo);
    c_clear_then_load: cover property (clrActive[0] ##[1:50] ldFall);
    c_strobe_load: cover property (ldFall && !clearPin);
    c_crc_readback: cover property (readGo && crcOn);
endmodule

`default_nettype wire

// >>> verification/dacc_host_model.sv
// Host-side model of the serial command link controller
`timescale 1ns/1ns
`default_nettype none
module dacc_host_model (
    // Serial link
    output logic serialClk,
    output logic frameSelN,
    output logic serialIn,
    input wire logic serialOut,
    input wire logic serialOutEn,
    // Captured reply
    output logic [31:0] rxWord,
    output logic rxStrobe
);
    initial begin
        serialClk = 1'b0;
        frameSelN = 1'b1;
        serialIn = 1'b0;
        rxWord = 32'h0000_0000;
        rxStrobe = 1'b0;
    end

    // Check code of a command, MSB first from a zero remainder
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction

    // Sends the low n bits of f; clock stands still outside the frame
    task automatic xfer(input logic [31:0] f, input int n);
        rxWord = 32'h0000_0000;
        frameSelN = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serialIn = f[i];
            #24;
            rxWord = {rxWord[30:0], serialOutEn ? serialOut : 1'bz};
            serialClk = 1'b1;
            #24;
            serialClk = 1'b0;
        end
        #24;
        frameSelN = 1'b1;
        // Released line shows no stale level
        serialIn = ~serialIn;
        rxStrobe = 1'b1;
        // Gap lets the core commit and settle readback
        #700;
        rxStrobe = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the DAC control core
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin failCount++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb;
    import dacc_pkg::*;
    // Arbitrary identity value
    localparam logic [2:0] PART = 3'h6;
    localparam logic [6:0] RA[6] = '{ADDR_GAIN_TRIM, ADDR_FAULT_STATUS, ADDR_PART_ID, ADDR_CHAN_SEL, 7'h0F, 7'h12};
    localparam logic [15:0] RV[6] = '{GAIN_RESET, STATUS_RESET, {13'h0000, PART}, 16'h0000, 16'h0000, 16'h0000};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic outputClearInput = 1'b0;
    logic outputLoadStrobeN = 1'b1;
    wire serialClk, frameSelN, serialIn, serialOut, serialOutEn, faultN, rxStrobe;
    wire [31:0] rxWord;
    wire [NUM_CH-1:0][CODE_W-1:0] dacCode;
    int failCount = 0;
    int compares = 0;
    logic crcOn = 1'b0;
    logic [31:0] expQ[$];
    logic [31:0] expWord;
    logic [15:0] expOut[NUM_CH];
    logic [15:0] keep[NUM_CH];

    always #50 ref_clk = ~ref_clk;

    dacc_control_core #(.PART_ID(PART)) dut (.ref_clk(ref_clk), .rst(rst), .serialClk(serialClk),
        .frameSelN(frameSelN), .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .outputClearInput(outputClearInput), .outputLoadStrobeN(outputLoadStrobeN), .faultN(faultN),
        .dacCode(dacCode));
    dacc_host_model host (.serialClk(serialClk), .frameSelN(frameSelN), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEn(serialOutEn), .rxWord(rxWord), .rxStrobe(rxStrobe));

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic send(input logic [23:0] c);
        if (crcOn) host.xfer({c, host.crc8(c)}, 32);
        else host.xfer({8'h00, c}, 24);
    endtask

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        send({1'b0, a, d});
    endtask

    // Reply arrives during the following no-op frame
    task automatic rd(input logic [6:0] a, input logic [15:0] d);
        send({1'b1, a, 16'h0000});
        expQ.push_back(crcOn ? {1'b1, a, d, host.crc8({1'b1, a, d})} : {8'h00, 1'b1, a, d});
        send(24'h00_0000);
    endtask

    task automatic pulseLoad();
        cyc(1);
        outputLoadStrobeN = 1'b0;
        cyc(4);
        outputLoadStrobeN = 1'b1;
        cyc(4);
    endtask

    task automatic checkOuts();
        for (int ch = 0; ch < NUM_CH; ch++) begin
            `CHECK("dacCode", expOut[ch], dacCode[ch])
        end
    endtask

    task automatic giveVerdict();
        $display("compares %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge rxStrobe) begin
        if (expQ.size() > 0) begin
            expWord = expQ.pop_front();
            `CHECK("readback", expWord, rxWord)
        end
    end

    initial begin
        #1_000_000;
        failCount++;
        giveVerdict();
    end

    initial begin
        logic [15:0] code, gain, offs;
        longint t;
        void'($urandom(32'h09d5_9387));
        cyc(2);
        `CHECK("faultN", 1'b1, faultN)
        `CHECK("dacCode", {NUM_CH{CODE_ZERO}}, dacCode)
        `CHECK("serialOutEn", 1'b0, serialOutEn)
        cyc(1);
        rst = 1'b0;
        cyc(4);
        `CHECK("dacCode", {NUM_CH{CODE_ZERO}}, dacCode)
        for (int i = 0; i < 6; i++) rd(RA[i], RV[i]);
        $display("test reset values done");
        // Short frame is dropped, padded frame uses its last 24 bits
        host.xfer({9'h000, ADDR_CHAN_SEL, 16'h01E0}, 23);
        rd(ADDR_CHAN_SEL, 16'h0000);
        host.xfer({8'hA5, 1'b0, ADDR_CHAN_SEL, 16'h01E0}, 32);
        rd(ADDR_CHAN_SEL, 16'h01E0);
        $display("test frame length done");
        // Odd channels trimmed; ch1 forced to low limit, ch3 to high limit
        wr(ADDR_CONV_SEL, 16'h000F);
        for (int ch = 0; ch < NUM_CH; ch++) begin
            code = 16'($urandom);
            gain = (ch == 3) ? 16'hFFFF : 16'($urandom);
            offs = (ch == 3) ? 16'h7FFF : (ch == 1) ? 16'h8000 : 16'($urandom);
            if (ch == 1) code = code & 16'h3FFF;
            if (ch == 3) code = code | 16'hC000;
            wr(ADDR_CHAN_SEL, 16'h0020 << ch);
            wr(ADDR_TRIM_EN, {15'h0000, ch[0]});
            wr(ADDR_GAIN_TRIM, gain);
            wr(ADDR_OFFSET_TRIM, offs);
            wr(ADDR_CHAN_CODE, code);
            t = ((longint'(code) * (longint'(gain) + 32768)) >>> 16) + longint'($signed(offs));
            expOut[ch] = !ch[0] ? code : (t < 0) ? 16'h0000 : (t > 65535) ? 16'hFFFF : 16'(t);
        end
        rd(ADDR_GAIN_TRIM, 16'hFFFF);
        pulseLoad();
        checkOuts();
        $display("test trim done");
        // Channel 3 not allowed to clear; channel 1 clears to midscale
        wr(ADDR_RESET_CFG, 16'h0E00);
        wr(ADDR_CHAN_SEL, 16'h0400);
        keep = expOut;
        expOut[0] = CODE_ZERO;
        expOut[1] = CODE_MID;
        expOut[2] = CODE_ZERO;
        cyc(1);
        outputClearInput = 1'b1;
        cyc(6);
        checkOuts();
        pulseLoad();
        checkOuts();
        outputClearInput = 1'b0;
        cyc(6);
        checkOuts();
        rd(ADDR_CHAN_CODE, keep[0]);
        expOut = keep;
        pulseLoad();
        checkOuts();
        $display("test clear done");
        wr(ADDR_CHAN_SEL, 16'h0008);
        crcOn = 1'b1;
        wr(ADDR_RESET_CFG, 16'h0200);
        rd(ADDR_RESET_CFG, 16'h0200);
        host.xfer({1'b0, ADDR_RESET_CFG, 16'h0000, 8'h00}, 32);
        cyc(2);
        `CHECK("faultN", 1'b0, faultN)
        rd(ADDR_RESET_CFG, 16'h0200);
        rd(ADDR_FAULT_STATUS, 16'h1020);
        wr(ADDR_CHAN_SEL, 16'h0000);
        crcOn = 1'b0;
        cyc(3);
        `CHECK("faultN", 1'b1, faultN)
        rd(ADDR_FAULT_STATUS, STATUS_RESET);
        $display("test frame check done");
        wr(ADDR_SOFT_RESET, 16'h0001);
        rd(ADDR_RESET_CFG, 16'h0000);
        rd(ADDR_SOFT_RESET, 16'h0000);
        $display("test soft reset done");
        giveVerdict();
    end
endmodule
`default_nettype wire
